// ==== adc_ctl_pkg.sv ====
// package of offsets, field layouts, reset values and encodings for the converter control block
package adc_ctl_pkg;

   // ***********************************************************
   // register map (byte offsets on the plain register port)
   // ***********************************************************
   localparam logic [3:0] ofs_pin_ctl_low  = 4'h0;  // channels 0..7
   localparam logic [3:0] ofs_pin_ctl_mid  = 4'h1;  // channels 8..15
   localparam logic [3:0] ofs_pin_ctl_high = 4'h2;  // channels 16..23
   localparam logic [3:0] ofs_status_ctl   = 4'h3;  // done flag, irq enable, compare enable, channel
   localparam logic [3:0] ofs_config       = 4'h4;  // divide, mode, clock select
   localparam logic [3:0] ofs_result_high  = 4'h5;  // upper result bits
   localparam logic [3:0] ofs_result_low   = 4'h6;  // lower result bits
   localparam logic [3:0] ofs_compare_high = 4'h7;  // compare value upper bits
   localparam logic [3:0] ofs_compare_low  = 4'h8;  // compare value lower bits
   localparam logic [3:0] ofs_raw_high     = 4'h9;  // raw successive-approximation word, upper
   localparam logic [3:0] ofs_raw_low      = 4'ha;  // raw word, lower; writing it while busy models a finished conversion

   // ***********************************************************
   // field positions
   // ***********************************************************
   localparam int sc_done_bit    = 7;
   localparam int sc_irq_en_bit  = 6;
   localparam int sc_cmp_en_bit  = 5;
   localparam int sc_cmp_gt_bit  = 4;
   localparam int cfg_div_lsb    = 5;
   localparam int cfg_mode_lsb   = 2;
   localparam int cfg_clk_lsb    = 0;

   // ***********************************************************
   // reset values
   // ***********************************************************
   localparam logic [7:0] pin_ctl_reset   = 8'h00;
   localparam logic [4:0] channel_reset   = 5'h1f;  // all ones: converter off
   localparam logic [4:0] channel_off     = 5'h1f;
   localparam logic [1:0] clk_sel_reset   = 2'h0;
   localparam logic [1:0] div_sel_reset   = 2'h0;
   localparam logic [1:0] mode_reset      = 2'h0;
   localparam logic [2:0] div_cnt_reset   = 3'h0;

   // ***********************************************************
   // encodings
   // ***********************************************************
   localparam logic [1:0] clk_bus      = 2'h0;
   localparam logic [1:0] clk_bus_half = 2'h1;
   localparam logic [1:0] clk_alt      = 2'h2;
   localparam logic [1:0] clk_async    = 2'h3;

   localparam logic [1:0] mode_8bit    = 2'h0;
   localparam logic [1:0] mode_12bit   = 2'h1;
   localparam logic [1:0] mode_10bit   = 2'h2;

   // converter activity states, one-hot
   typedef enum logic [2:0]
   {
      st_off  = 3'b001,
      st_idle = 3'b010,
      st_busy = 3'b100
   } conv_state_t;

endpackage

// ==== adc_pin_and_clock_control.sv ====
// control around a successive-approximation converter: pin release, clocks, result placement
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/100ps
// ***********************************************************
// Overview of operation
// RULE1: low register bits release channels 0-7
// RULE2: mid register bits release channels 8-15
// RULE3: high register bits release channels 16-23
// RULE4: released pin output driver held off
// RULE5: released pin input off, reads zero
// RULE6: released pin pullup forced off
// RULE7: converter off in reset or channel ones
// RULE8: idle lowest power between conversions
// RULE9: raw result 12 bits, 9 in 8-bit
// RULE10: 10-bit mode rounds, fills both registers
// RULE11: 8-bit mode rounds, fills low only
// RULE12: set done flag, request irq if enabled
// RULE13: compare enable gates result on condition
// RULE14: clock select picks one of four
// RULE15: reset selects bus clock
// RULE16: selected source divided by 1,2,4,8
// RULE17: half bus and divide 8 gives 16
// RULE18: async clock runs in wait and stop3
// RULE19: clock select encodes 00,01,10,11 sources
// RULE20: divide field 00..11 gives 1,2,4,8
// RULE21: mode 00 8-bit, 01 12-bit, 10 10-bit
// RULE22: pin-control bits clear on reset
// ***********************************************************
module adc_pin_and_clock_control
(
   input  wire logic        clk,              // bus clock, 250 MHz
   input  wire logic        resetn,           // asynchronous reset, active low
   input  wire logic [3:0]  reg_addr,         // register offset
   input  wire logic [7:0]  reg_wdata,        // write data
   input  wire logic        reg_wr,           // write strobe
   input  wire logic        reg_rd,           // read strobe
   output logic      [7:0]  reg_rdata,        // read data, valid cycle after read strobe
   input  wire logic        alternate_clock,  // alternate source, asynchronous pin
   input  wire logic        internal_async_clock, // internal oscillator, asynchronous
   input  wire logic        low_power_mode,   // wait or stop3 requested
   input  wire logic [23:0] port_out,         // port output data
   input  wire logic [23:0] port_drive,       // port wants to drive the pin
   input  wire logic [23:0] port_pullup,      // port pullup enable
   input  wire logic [23:0] pin_in,           // pin levels from the pads
   output logic      [23:0] pin_out,          // pad output data
   output logic      [23:0] pin_oe_n,         // pad output enable, low drives
   output logic      [23:0] pin_pullup_en,    // pad pullup enable
   output logic      [23:0] pin_ibuf_en,      // pad input buffer enable
   output logic      [23:0] port_read,        // value the port sees on read
   output logic             conversion_clock, // enable pulse of the conversion clock
   output logic             async_osc_run,    // internal oscillator kept running
   output logic             converter_on,     // analog core powered
   output logic             done_irq          // conversion complete interrupt request
);

   // ***********************************************************
   // register state
   // ***********************************************************
   logic [23:0] pin_release_r, pin_release_nxt;   // one bit per analog pin
   logic [4:0]  channel_select_r, channel_select_nxt;
   logic        done_r, done_nxt;                 // conversion_done_flag
   logic        irq_en_r, irq_en_nxt;             // done_irq_enable
   logic        cmp_en_r, cmp_en_nxt;             // compare_enable
   logic        cmp_gt_r, cmp_gt_nxt;             // compare direction
   logic [1:0]  clk_sel_r, clk_sel_nxt;           // input_clock_select
   logic [1:0]  div_sel_r, div_sel_nxt;           // clock_divide_select
   logic [1:0]  mode_r, mode_nxt;                 // resolution
   logic [3:0]  cmp_high_r, cmp_high_nxt;
   logic [7:0]  cmp_low_r, cmp_low_nxt;
   logic [3:0]  raw_high_r, raw_high_nxt;         // staged raw word, upper nibble
   logic [3:0]  result_high_r, result_high_nxt;
   logic [7:0]  result_low_r, result_low_nxt;
   logic [7:0]  rdata_nxt;
   adc_ctl_pkg::conv_state_t state_r, state_nxt;

   // ***********************************************************
   // input synchronisers (three stages, agree on last two)
   // ***********************************************************
   logic [2:0] alt_sync_r, async_sync_r;
   logic       alt_lvl_r, async_lvl_r;   // filtered levels
   logic       alt_prev_r, async_prev_r; // for rising-edge detection
   logic       alt_rise, async_rise;

   // the first stage is read only by the second; filtered level moves when stages 2 and 3 agree
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         alt_sync_r   <= 3'h0;
         async_sync_r <= 3'h0;
         alt_lvl_r    <= 1'b0;
         async_lvl_r  <= 1'b0;
         alt_prev_r   <= 1'b0;
         async_prev_r <= 1'b0;
      end
      else
      begin
         alt_sync_r   <= {alt_sync_r[1:0], alternate_clock};
         async_sync_r <= {async_sync_r[1:0], internal_async_clock};
         if (alt_sync_r[1] == alt_sync_r[2])
            alt_lvl_r <= alt_sync_r[2];
         if (async_sync_r[1] == async_sync_r[2])
            async_lvl_r <= async_sync_r[2];
         alt_prev_r   <= alt_lvl_r;
         async_prev_r <= async_lvl_r;
      end
   end

   assign alt_rise   = alt_lvl_r & ~alt_prev_r;
   assign async_rise = async_lvl_r & ~async_prev_r;

   // ***********************************************************
   // conversion clock: source select then divide
   // ***********************************************************
   logic       half_r, half_nxt;       // bus clock halving toggle
   logic [2:0] div_cnt_r, div_cnt_nxt; // divider count of source ticks
   logic       src_tick;               // one tick of the selected source
   logic       div_tick;               // divided output tick
   logic [2:0] div_last;               // terminal count for chosen ratio
   logic       ck_en_r;

   // source and divider next values; while not busy the divider is held at its reset count
   always_comb
   begin
      half_nxt = ~half_r;
      unique case (clk_sel_r)                                  // see RULE14 see RULE19
         adc_ctl_pkg::clk_bus      : src_tick = 1'b1;
         adc_ctl_pkg::clk_bus_half : src_tick = half_r;         // see RULE17
         adc_ctl_pkg::clk_alt      : src_tick = alt_rise;
         adc_ctl_pkg::clk_async    : src_tick = async_rise;
      endcase
      unique case (div_sel_r)                                  // see RULE16 see RULE20
         2'h0    : div_last = 3'h0;
         2'h1    : div_last = 3'h1;
         2'h2    : div_last = 3'h3;
         2'h3    : div_last = 3'h7;
      endcase
      div_cnt_nxt = div_cnt_r;
      div_tick    = 1'b0;
      if (state_r != adc_ctl_pkg::st_busy)
         div_cnt_nxt = adc_ctl_pkg::div_cnt_reset;              // see RULE8
      else if (src_tick)
      begin
         if (div_cnt_r >= div_last)
         begin
            div_cnt_nxt = adc_ctl_pkg::div_cnt_reset;
            div_tick    = 1'b1;
         end
         else
            div_cnt_nxt = div_cnt_r + 3'h1;
      end
   end

   // divider registers
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         half_r    <= 1'b0;
         div_cnt_r <= adc_ctl_pkg::div_cnt_reset;
         ck_en_r   <= 1'b0;
      end
      else
      begin
         half_r    <= half_nxt;
         div_cnt_r <= div_cnt_nxt;
         ck_en_r   <= div_tick;
      end
   end

   // ***********************************************************
   // result rounding, placement and compare
   // ***********************************************************
   logic [11:0] raw_word;      // 12-bit raw, 9-bit raw in its low bits for 8-bit mode
   logic [10:0] round10;       // rounded 10-bit plus carry
   logic [8:0]  round8;        // rounded 8-bit plus carry
   logic [11:0] placed;        // result as it would land in the registers
   logic [11:0] cmp_value;
   logic        cmp_hit;
   logic        finish;

   always_comb
   begin
      raw_word  = {raw_high_r, reg_wdata};
      // round half up, saturating so a full-scale raw word stays full scale
      round10   = {1'b0, raw_word[11:2]} + {10'h000, raw_word[1]};          // see RULE10
      round8    = {1'b0, raw_word[8:1]} + {8'h00, raw_word[0]};             // see RULE9 see RULE11
      unique case (mode_r)                                                  // see RULE21
         adc_ctl_pkg::mode_12bit : placed = raw_word;
         adc_ctl_pkg::mode_10bit : placed = {2'h0, (round10[10] ? 10'h3ff : round10[9:0])};
         adc_ctl_pkg::mode_8bit  : placed = {4'h0, (round8[8] ? 8'hff : round8[7:0])};
         default                 : placed = raw_word;   // reserved code behaves as 12-bit
      endcase
      cmp_value = (mode_r == adc_ctl_pkg::mode_8bit) ? {4'h0, cmp_low_r} : {cmp_high_r, cmp_low_r};
      cmp_hit   = cmp_gt_r ? (placed >= cmp_value) : (placed < cmp_value); // see RULE13
      finish    = reg_wr && (reg_addr == adc_ctl_pkg::ofs_raw_low) && (state_r == adc_ctl_pkg::st_busy);
   end

   // ***********************************************************
   // register file and converter sequencing
   // ***********************************************************
   logic wr_sc;
   logic done_set;

   // next values for every software register and the activity state
   always_comb
   begin
      pin_release_nxt    = pin_release_r;
      channel_select_nxt = channel_select_r;
      irq_en_nxt         = irq_en_r;
      cmp_en_nxt         = cmp_en_r;
      cmp_gt_nxt         = cmp_gt_r;
      clk_sel_nxt        = clk_sel_r;
      div_sel_nxt        = div_sel_r;
      mode_nxt           = mode_r;
      cmp_high_nxt       = cmp_high_r;
      cmp_low_nxt        = cmp_low_r;
      raw_high_nxt       = raw_high_r;
      result_high_nxt    = result_high_r;
      result_low_nxt     = result_low_r;
      state_nxt          = state_r;
      wr_sc              = reg_wr && (reg_addr == adc_ctl_pkg::ofs_status_ctl);
      done_set           = 1'b0;
      done_nxt           = done_r;
      if (reg_wr)
      begin
         unique case (reg_addr)
            adc_ctl_pkg::ofs_pin_ctl_low  : pin_release_nxt[7:0]   = reg_wdata;  // see RULE1
            adc_ctl_pkg::ofs_pin_ctl_mid  : pin_release_nxt[15:8]  = reg_wdata;  // see RULE2
            adc_ctl_pkg::ofs_pin_ctl_high : pin_release_nxt[23:16] = reg_wdata;  // see RULE3
            adc_ctl_pkg::ofs_status_ctl   :
            begin
               irq_en_nxt         = reg_wdata[adc_ctl_pkg::sc_irq_en_bit];
               cmp_en_nxt         = reg_wdata[adc_ctl_pkg::sc_cmp_en_bit];
               cmp_gt_nxt         = reg_wdata[adc_ctl_pkg::sc_cmp_gt_bit];
               channel_select_nxt = reg_wdata[4:0];
            end
            adc_ctl_pkg::ofs_config       :
            begin
               div_sel_nxt = reg_wdata[adc_ctl_pkg::cfg_div_lsb +: 2];
               mode_nxt    = reg_wdata[adc_ctl_pkg::cfg_mode_lsb +: 2];
               clk_sel_nxt = reg_wdata[adc_ctl_pkg::cfg_clk_lsb +: 2];
            end
            adc_ctl_pkg::ofs_compare_high : cmp_high_nxt = reg_wdata[3:0];
            adc_ctl_pkg::ofs_compare_low  : cmp_low_nxt  = reg_wdata;
            adc_ctl_pkg::ofs_raw_high     : raw_high_nxt = reg_wdata[3:0];
            default                       : ;   // read-only, unmapped or raw low: nothing stored here; a raw low write is taken by finish
         endcase
      end
      // activity state: a status write starts a conversion unless the channel is all ones
      unique case (state_r)
         adc_ctl_pkg::st_off  :
            if (wr_sc && channel_select_nxt != adc_ctl_pkg::channel_off)
               state_nxt = adc_ctl_pkg::st_busy;
            else if (wr_sc)
               state_nxt = adc_ctl_pkg::st_off;
         adc_ctl_pkg::st_idle :
            if (wr_sc)
               state_nxt = (channel_select_nxt == adc_ctl_pkg::channel_off) ?
                           adc_ctl_pkg::st_off : adc_ctl_pkg::st_busy;   // see RULE7
         adc_ctl_pkg::st_busy :
            if (wr_sc)
               state_nxt = (channel_select_nxt == adc_ctl_pkg::channel_off) ?
                           adc_ctl_pkg::st_off : adc_ctl_pkg::st_busy;   // see RULE7
            else if (finish)
               state_nxt = adc_ctl_pkg::st_idle;                          // see RULE8
         default              : state_nxt = adc_ctl_pkg::st_off;
      endcase
      // a finished conversion lands only when compare is off or the condition holds
      if (finish && (!cmp_en_r || cmp_hit))                               // see RULE13
      begin
         result_high_nxt = placed[11:8];
         result_low_nxt  = placed[7:0];
         done_set        = 1'b1;
      end
      // a status write clears the flag, a landing result in the same cycle wins
      if (wr_sc)
         done_nxt = 1'b0;
      if (done_set)
         done_nxt = 1'b1;                                                 // see RULE12
      // reading the low result also clears the flag
      if (reg_rd && reg_addr == adc_ctl_pkg::ofs_result_low && !done_set)
         done_nxt = 1'b0;
      unique case (reg_addr)
         adc_ctl_pkg::ofs_pin_ctl_low  : rdata_nxt = pin_release_r[7:0];
         adc_ctl_pkg::ofs_pin_ctl_mid  : rdata_nxt = pin_release_r[15:8];
         adc_ctl_pkg::ofs_pin_ctl_high : rdata_nxt = pin_release_r[23:16];
         adc_ctl_pkg::ofs_status_ctl   : rdata_nxt = {done_r, irq_en_r, cmp_en_r, channel_select_r};
         adc_ctl_pkg::ofs_config       : rdata_nxt = {1'b0, div_sel_r, cmp_gt_r, mode_r, clk_sel_r};
         adc_ctl_pkg::ofs_result_high  : rdata_nxt = {4'h0, result_high_r};
         adc_ctl_pkg::ofs_result_low   : rdata_nxt = result_low_r;
         adc_ctl_pkg::ofs_compare_high : rdata_nxt = {4'h0, cmp_high_r};
         adc_ctl_pkg::ofs_compare_low  : rdata_nxt = cmp_low_r;
         adc_ctl_pkg::ofs_raw_high     : rdata_nxt = {5'h00, state_r};
         default                       : rdata_nxt = 8'h00;  // unmapped reads zero
      endcase
      if (!reg_rd)
         rdata_nxt = 8'h00;
   end

   // registers of the register file; all pins start under port control
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_release_r    <= {3{adc_ctl_pkg::pin_ctl_reset}};           // see RULE22
         channel_select_r <= adc_ctl_pkg::channel_reset;
         done_r           <= 1'b0;
         irq_en_r         <= 1'b0;
         cmp_en_r         <= 1'b0;
         cmp_gt_r         <= 1'b0;
         clk_sel_r        <= adc_ctl_pkg::clk_sel_reset;                // see RULE15
         div_sel_r        <= adc_ctl_pkg::div_sel_reset;
         mode_r           <= adc_ctl_pkg::mode_reset;
         cmp_high_r       <= 4'h0;
         cmp_low_r        <= 8'h00;
         raw_high_r       <= 4'h0;
         result_high_r    <= 4'h0;
         result_low_r     <= 8'h00;
         state_r          <= adc_ctl_pkg::st_off;                       // see RULE7
         reg_rdata        <= 8'h00;
      end
      else
      begin
         pin_release_r    <= pin_release_nxt;
         channel_select_r <= channel_select_nxt;
         done_r           <= done_nxt;
         irq_en_r         <= irq_en_nxt;
         cmp_en_r         <= cmp_en_nxt;
         cmp_gt_r         <= cmp_gt_nxt;
         clk_sel_r        <= clk_sel_nxt;
         div_sel_r        <= div_sel_nxt;
         mode_r           <= mode_nxt;
         cmp_high_r       <= cmp_high_nxt;
         cmp_low_r        <= cmp_low_nxt;
         raw_high_r       <= raw_high_nxt;
         result_high_r    <= result_high_nxt;
         result_low_r     <= result_low_nxt;
         state_r          <= state_nxt;
         reg_rdata        <= rdata_nxt;
      end
   end

   // ***********************************************************
   // pad overrides and status outputs, all registered
   // ***********************************************************
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_out          <= 24'h000000;
         pin_oe_n         <= 24'hffffff;
         pin_pullup_en    <= 24'h000000;
         pin_ibuf_en      <= 24'hffffff;
         port_read        <= 24'h000000;
         conversion_clock <= 1'b0;
         async_osc_run    <= 1'b0;
         converter_on     <= 1'b0;
         done_irq         <= 1'b0;
      end
      else
      begin
         pin_out          <= port_out & ~pin_release_r;
         pin_oe_n         <= ~port_drive | pin_release_r;                 // see RULE4
         pin_pullup_en    <= port_pullup & ~pin_release_r;                // see RULE6
         pin_ibuf_en      <= ~pin_release_r;                              // see RULE5
         port_read        <= pin_in & ~pin_release_r;                     // see RULE5
         conversion_clock <= ck_en_r;
         // oscillator runs whenever it clocks a conversion, also through wait and stop3
         async_osc_run    <= (state_r == adc_ctl_pkg::st_busy) &&
                             (clk_sel_r == adc_ctl_pkg::clk_async);       // see RULE18
         converter_on     <= (state_r == adc_ctl_pkg::st_busy) &&
                             (!low_power_mode || clk_sel_r == adc_ctl_pkg::clk_async); // see RULE18 see RULE8
         done_irq         <= done_nxt & irq_en_nxt;                       // see RULE12
      end
   end

endmodule // adc_pin_and_clock_control

// ==== adc_ctl_properties.sv ====
// concurrent checks on the ports of the converter control block
`timescale 1ns/100ps
module adc_ctl_props
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic [23:0] pin_in,
   input wire logic [23:0] port_pullup,
   input wire logic [23:0] pin_oe_n,
   input wire logic [23:0] pin_pullup_en,
   input wire logic [23:0] pin_ibuf_en,
   input wire logic [23:0] port_read,
   input wire logic        converter_on,
   input wire logic        async_osc_run
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // a released pin is one whose input buffer is off
   sequence s_no_read;
      !reg_rd;
   endsequence
   a_oe_released: assert property ((~pin_ibuf_en & ~pin_oe_n) == 24'h0) else $error("released pin driven");
   a_read_zero: assert property ((~pin_ibuf_en & port_read) == 24'h0) else $error("released pin reads one");
   a_pullup_off: assert property ((~pin_ibuf_en & pin_pullup_en) == 24'h0) else $error("pullup left on");
   a_read_follows: assert property ($past(resetn) |-> port_read == ($past(pin_in) & pin_ibuf_en))
      else $error("port read wrong");
   a_pullup_follows: assert property ($past(resetn) |-> pin_pullup_en == ($past(port_pullup) & pin_ibuf_en))
      else $error("pullup wrong");
   a_rdata_quiet: assert property (s_no_read |=> reg_rdata == 8'h00) else $error("read data outside slot");
   a_osc_powered: assert property (async_osc_run |-> converter_on) else $error("oscillator without converter");
   a_reset_pins: assert property ($rose(resetn) |-> (&pin_oe_n) && (&pin_ibuf_en)) else $error("pins not free");
endmodule // adc_ctl_props
bind adc_pin_and_clock_control adc_ctl_props adc_ctl_props_i (.clk, .resetn, .reg_rd, .reg_rdata, .pin_in,
   .port_pullup, .pin_oe_n, .pin_pullup_en, .pin_ibuf_en, .port_read, .converter_on, .async_osc_run);

// ==== pad_port_model.sv ====
// pads seen from the block: driven pins read back, undriven pulled pins read high
`timescale 1ns/100ps
module pad_port_model
(
   input wire logic        clk,
   input wire logic [23:0] pin_out,
   input wire logic [23:0] pin_oe_n,
   input wire logic [23:0] pin_pullup_en,
   output logic     [23:0] pin_in
);
   logic [23:0] float_r;  // an open pin wanders every cycle, never a stale level
   initial float_r = 24'h5a5a5a;
   always @(posedge clk) float_r <= ~float_r;
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & (pin_pullup_en | float_r));
endmodule // pad_port_model

// ==== adc_pin_and_clock_control_bench.sv ====
// self-checking bench for the converter control block
`timescale 1ns/100ps
module adc_pin_and_clock_control_bench;
   logic        clk, resetn, reg_wr, reg_rd, alternate_clock, internal_async_clock, low_power_mode, rd_seen;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, exp_q[$];
   logic [23:0] port_out, port_drive, port_pullup, pin_in, pin_out, pin_oe_n, pin_pullup_en, pin_ibuf_en, port_read, rel;
   logic        conversion_clock, async_osc_run, converter_on, done_irq;
   int          miscompares = 0, tests_run = 0;
   adc_pin_and_clock_control adc_pin_and_clock_control_i (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .alternate_clock, .internal_async_clock, .low_power_mode, .port_out, .port_drive, .port_pullup,
      .pin_in, .pin_out, .pin_oe_n, .pin_pullup_en, .pin_ibuf_en, .port_read, .conversion_clock, .async_osc_run,
      .converter_on, .done_irq);
   pad_port_model pad_port_model_i (.clk, .pin_out, .pin_oe_n, .pin_pullup_en, .pin_in);
   initial begin clk = 1'b0; forever #2 clk = ~clk; end
   initial begin alternate_clock = 1'b0; forever #5.3 alternate_clock = ~alternate_clock; end
   initial begin internal_async_clock = 1'b0; forever #7.1 internal_async_clock = ~internal_async_clock; end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a; reg_rd <= 1'b1; exp_q.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe: compare the oldest note then
   always @(posedge clk)
   begin
      if (rd_seen) chk(24'(reg_rdata), 24'(exp_q.pop_front()));
      rd_seen <= reg_rd;
   end
   // one conversion: start, time the clock ticks, inject the raw word, check placement
   task automatic conv(input logic [7:0] cfg, input logic [11:0] raw, input logic [7:0] eh, el, input int gap,
                       input logic [7:0] sc);
      int n;
      wr(adc_ctl_pkg::ofs_config, cfg);
      wr(adc_ctl_pkg::ofs_status_ctl, sc);  // channel and enables from the caller
      repeat (3) @(negedge clk);
      chk(24'({converter_on, async_osc_run}), 24'({1'b1, cfg[1:0] == adc_ctl_pkg::clk_async}));
      n = 0;
      while (!conversion_clock && n < 100) begin @(negedge clk); n++; end
      chk(24'(n < 100), 24'h1);
      n = 0;
      if (gap > 0)
      begin
         do begin @(negedge clk); n++; end while (!conversion_clock && n < 40);
         chk(24'(n), 24'(gap));
      end
      wr(adc_ctl_pkg::ofs_raw_high, 8'(raw[11:8]));
      wr(adc_ctl_pkg::ofs_raw_low, raw[7:0]);
      repeat (3) @(negedge clk);
      chk(24'({done_irq, converter_on}), 24'h2);
      rd(adc_ctl_pkg::ofs_result_high, eh);
      rd(adc_ctl_pkg::ofs_result_low, el);
   endtask
   task automatic summarize();
      if (miscompares == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // hang guard, far beyond the well under a thousand cycles the run needs
   initial begin #100000; miscompares++; summarize(); end
   initial
   begin
      resetn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00; rd_seen = 1'b0;
      low_power_mode = 1'b0; port_out = 24'h0; port_drive = 24'h0; port_pullup = 24'h0; rel = 24'h0;
      void'($urandom(72));
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      rd(4'h0, 8'h00); rd(4'h1, 8'h00); rd(4'h2, 8'h00); rd(4'hf, 8'h00);
      rd(adc_ctl_pkg::ofs_config, 8'h00);
      rd(adc_ctl_pkg::ofs_status_ctl, 8'h1f);
      repeat (4)
      begin
         @(posedge clk);
         rel = 24'($urandom);
         port_out <= 24'($urandom); port_drive <= 24'($urandom); port_pullup <= 24'($urandom);
         wr(4'h0, rel[7:0]); wr(4'h1, rel[15:8]); wr(4'h2, rel[23:16]);
         rd(4'h0, rel[7:0]); rd(4'h1, rel[15:8]); rd(4'h2, rel[23:16]);
         repeat (4) @(negedge clk);
         chk(pin_oe_n, ~port_drive | rel);
         chk(pin_ibuf_en, ~rel);
         chk(pin_pullup_en, port_pullup & ~rel);
         chk(port_read & (port_drive | port_pullup), ((port_out & port_drive) | (port_pullup & ~port_drive)) & ~rel);
      end
      for (int s = 0; s < 4; s++)
         for (int d = 0; d < 4; d++)
         begin
            low_power_mode <= (s == 3);
            rel = 24'($urandom);
            conv(8'((d << 5) | 4 | s), rel[11:0], 8'(rel[11:8]), rel[7:0], (s < 2) ? ((s + 1) << d) : 0, 8'h40);
         end
      low_power_mode <= 1'b0;
      conv(8'h08, 12'h7a6, 8'h01, 8'hea, 1, 8'h40);
      conv(8'h00, 12'h0f3, 8'h00, 8'h7a, 1, 8'h40);
      wr(4'h8, 8'h10); conv(8'h08, 12'h3ff, 8'h01, 8'h00, 1, 8'h70);
      wr(4'h3, 8'h60); wr(4'ha, 8'h04); rd(4'h3, 8'h60); rd(4'h6, 8'h00);
      wr(adc_ctl_pkg::ofs_status_ctl, 8'h1f);
      repeat (3) @(negedge clk);
      chk(24'(converter_on), 24'h0);
      @(posedge clk) resetn <= 1'b0;
      @(posedge clk) resetn <= 1'b1;
      rd(4'h0, 8'h00);
      repeat (3) @(posedge clk);
      summarize();
   end
endmodule // adc_pin_and_clock_control_bench
